// ==== design/psfm_buf.sv ====
// Two-entry word buffer with registered head, valid/ready on both sides
`timescale 1ns/1ps
module psfm_buf #(
    parameter int W = 32
) (
    input wire logic clock,
    input wire logic rst_b,
    psfm_stream_if.buffer s
);
    logic [W-1:0] head;
    logic [W-1:0] tail;
    logic head_full;
    logic tail_full;
    logic push;
    logic pop;

    // Full only when the second slot holds a word
    assign s.in_ready = ~tail_full;
    assign s.out_valid = head_full;
    assign s.out_data = head;
    assign push = s.in_valid & ~tail_full;
    assign pop = head_full & s.out_ready;

    // Head is the output register, tail absorbs one stalled word
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            head <= '0;
            tail <= '0;
            head_full <= 1'b0;
            tail_full <= 1'b0;
        end else if (pop) begin
            if (tail_full) begin
                head <= tail;
                tail_full <= 1'b0;
            end else if (push) begin
                head <= s.in_data;
            end else begin
                head_full <= 1'b0;
            end
        end else if (push) begin
            if (!head_full) begin
                head <= s.in_data;
                head_full <= 1'b1;
            end else begin
                tail <= s.in_data;
                tail_full <= 1'b1;
            end
        end
    end
endmodule : psfm_buf

// ==== design/psfm_top.sv ====
// Phased serial flash master: runs up to eight programmed steps on a serial NOR flash
`timescale 1ns/1ps
`include "psfm_map.svh"

// How it works
// RL1: Go runs steps from zero up; step total is count minus one.
// RL2: Receive bytes land in the step's own word, readable after the end.
// RL3: Finishing a transaction clears the go flag.
// RL4: Poll reads bytes, compares masked value, stops on match or attempt ceiling.
// RL5: A poll ending without match sets the error flag.
// RL6: Transmit sends word from byte zero; byte order select picks its end.
// RL7: Dummy transmit sends filler bytes, transfer length of them, on configured lanes.
// RL8: With DMA assist, each filled receive word raises a DMA request.
// RL9: Each step moves exactly transfer length bytes, except poll steps, which move one byte per attempt.
// RL10: Flash repeats its status byte while chip select stays low.
// RL11: Lane field: zero single, one dual, two quad; three not allowed. The code runs code three as single lane.
// RL12: Kind field: zero transmit, one dummy, two receive, three poll.
// RL13: Poll word fields, high to low: ceiling, mask, wanted, sampled.
// RL14: Chip select low from first step start until last step completes.
module psfm_top #(
    parameter int HALF = `PSFM_HALF_CYC
) (
    input wire logic clock,
    input wire logic rst_b,
    input wire logic go_set,
    input wire logic [2:0] step_total,
    input wire logic byte_order_select,
    input wire logic use_dma,
    input wire logic [`PSFM_STEPS*32-1:0] step_setup,
    input wire logic [`PSFM_STEPS*32-1:0] step_word_in,
    input wire logic [3:0] io_in,
    input wire logic dma_ready,
    output psfm_pkg::psfm_word_t dma_data,
    output logic dma_req,
    output logic go,
    output logic error,
    output logic done,
    output logic chip_select_n,
    output logic sclk,
    output logic [3:0] io_out,
    output logic [3:0] io_oe,
    output logic [`PSFM_STEPS*32-1:0] step_word
);
    import psfm_pkg::*;

    psfm_state_t state;
    psfm_word_t word [`PSFM_STEPS];
    logic [3:0] io_meta;
    logic [3:0] io_sync;
    logic [2:0] step;
    logic [1:0] mode;
    logic [1:0] kind;
    logic [11:0] len;
    logic [11:0] bcnt;
    logic [7:0] tries;
    logic [7:0] sh;
    logic [7:0] rsh;
    logic [7:0] next_sh;
    logic [7:0] next_rsh;
    logic [2:0] bitleft;
    logic [7:0] div;
    logic [1:0] lane_idx;
    logic [4:0] lane_pos;
    logic last_byte;
    logic poll_hit;
    logic [31:0] cur_setup;
    psfm_stream_if #(.W(32)) rxs ();

    // Receive words queue here so a stalled DMA costs no data
    psfm_buf #(.W(32)) u_buf (
        .clock(clock),
        .rst_b(rst_b),
        .s(rxs.buffer)
    );
    assign rxs.in_valid = (state == psfm_push);
    assign rxs.in_data = word[step];
    assign rxs.out_ready = dma_ready;
    assign dma_req = rxs.out_valid; // see RL8
    assign dma_data = rxs.out_data;

    // Flatten the step words for software to read
    for (genvar g = 0; g < `PSFM_STEPS; g++) begin : g_words
        assign step_word[g*32 +: 32] = word[g];
    end

    // Byte slot within the word follows byte order select
    assign lane_idx = byte_order_select ? bcnt[1:0] : 2'h3 - bcnt[1:0]; // see RL6
    assign lane_pos = {lane_idx, 3'h0};
    assign last_byte = (bcnt + 12'h001 == len); // see RL9
    assign cur_setup = step_setup[step*32 +: 32];
    // Masked sampled byte against wanted value
    assign poll_hit = ((rsh & word[step][`PSFM_POLL_MASK]) == word[step][`PSFM_POLL_WANT]); // see RL4 RL13

    // Sampled bits enter from the lanes the step uses
    always_comb begin
        case (mode)
            `PSFM_LANE_DUAL: begin
                next_rsh = {rsh[5:0], io_sync[1:0]};
                next_sh = {sh[5:0], 2'h0};
            end
            `PSFM_LANE_QUAD: begin
                next_rsh = {rsh[3:0], io_sync};
                next_sh = {sh[3:0], 4'h0};
            end
            default: begin
                next_rsh = {rsh[6:0], io_sync[1]};
                next_sh = {sh[6:0], 1'b0};
            end
        endcase
    end

    // Pin data from the flash crosses in two flops
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            io_meta <= 4'h0;
            io_sync <= 4'h0;
        end else begin
            io_meta <= io_in;
            io_sync <= io_meta;
        end
    end

    // Drive the lanes of the current mode; io2/io3 sit high in narrow modes
    function automatic logic [3:0] lanes(input logic [1:0] m, input logic [7:0] b);
        case (m)
            `PSFM_LANE_DUAL: lanes = {2'h3, b[7:6]};
            `PSFM_LANE_QUAD: lanes = b[7:4];
            default: lanes = {2'h3, 1'b0, b[7]};
        endcase
    endfunction : lanes

    // Step sequencer, bit clock divider and shifters
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            state <= psfm_idle;
            step <= 3'h0;
            mode <= `PSFM_LANE_SINGLE;
            kind <= `PSFM_KIND_TX;
            len <= 12'h000;
            bcnt <= 12'h000;
            tries <= 8'h00;
            sh <= 8'h00;
            rsh <= 8'h00;
            bitleft <= 3'h0;
            div <= 8'h00;
            go <= 1'b0;
            error <= 1'b0;
            done <= 1'b0;
            chip_select_n <= 1'b1;
            sclk <= 1'b0;
            io_out <= 4'h0;
            io_oe <= 4'h0;
            for (int i = 0; i < `PSFM_STEPS; i++) begin
                word[i] <= 32'h0000_0000;
            end
        end else begin
            case (state)
                psfm_idle: begin
                    // A go while busy is ignored; words load only at start
                    if (go_set) begin
                        for (int i = 0; i < `PSFM_STEPS; i++) begin
                            word[i] <= step_word_in[i*32 +: 32];
                        end
                        step <= 3'h0; // see RL1
                        go <= 1'b1;
                        error <= 1'b0;
                        done <= 1'b0;
                        chip_select_n <= 1'b0; // see RL14
                        state <= psfm_step;
                    end
                end
                psfm_step: begin
                    mode <= cur_setup[`PSFM_MODE_HI:`PSFM_MODE_LO]; // see RL11
                    kind <= cur_setup[`PSFM_KIND_HI:`PSFM_KIND_LO]; // see RL12
                    len <= cur_setup[`PSFM_LEN_HI:`PSFM_LEN_LO];
                    bcnt <= 12'h000;
                    tries <= 8'h00;
                    state <= psfm_prep;
                    // Zero-length non-poll steps move no byte at all
                    if (cur_setup[`PSFM_KIND_HI:`PSFM_KIND_LO] != `PSFM_KIND_POLL &&
                        cur_setup[`PSFM_LEN_HI:`PSFM_LEN_LO] == 12'h000) begin // see RL9
                        if (step == step_total) begin
                            state <= psfm_drain;
                            chip_select_n <= 1'b1;
                            go <= 1'b0;
                            io_oe <= 4'h0; // see RL14
                        end else begin
                            step <= step + 3'h1;
                            state <= psfm_step;
                        end
                    end
                end
                psfm_prep: begin
                    // Reserved lane code three behaves as single lane
                    bitleft <= (mode == `PSFM_LANE_QUAD) ? 3'h1 : (mode == `PSFM_LANE_DUAL) ? 3'h3 : 3'h7;
                    div <= 8'h00;
                    state <= psfm_low;
                    if (kind == `PSFM_KIND_TX) begin
                        sh <= word[step][lane_pos +: 8]; // see RL6
                        io_out <= lanes(mode, word[step][lane_pos +: 8]);
                    end else begin
                        sh <= `PSFM_FILLER; // see RL7
                        io_out <= lanes(mode, `PSFM_FILLER);
                    end
                    // Lane code three keeps io1 as an input, like single lane
                    if (kind == `PSFM_KIND_TX || kind == `PSFM_KIND_DUMMY ||
                        (mode != `PSFM_LANE_DUAL && mode != `PSFM_LANE_QUAD)) begin
                        io_oe <= (mode == `PSFM_LANE_DUAL || mode == `PSFM_LANE_QUAD) ? 4'hf : 4'hd; // see RL11
                    end else begin
                        io_oe <= (mode == `PSFM_LANE_DUAL) ? 4'hc : 4'h0;
                    end
                end
                psfm_low: begin
                    div <= div + 8'h01;
                    if (div == 8'(HALF - 1)) begin
                        div <= 8'h00;
                        sclk <= 1'b1;
                        state <= psfm_high;
                    end
                end
                psfm_high: begin
                    div <= div + 8'h01;
                    // Sample late in the high half, after the sync delay settles
                    if (div == 8'(HALF - 1)) begin
                        div <= 8'h00;
                        sclk <= 1'b0;
                        rsh <= next_rsh;
                        sh <= next_sh;
                        io_out <= lanes(mode, next_sh);
                        bitleft <= bitleft - 3'h1;
                        state <= (bitleft == 3'h0) ? psfm_end : psfm_low;
                    end
                end
                psfm_end: begin
                    bcnt <= bcnt + 12'h001;
                    state <= psfm_prep;
                    if (kind == `PSFM_KIND_POLL) begin
                        word[step][`PSFM_POLL_READ] <= rsh;
                        tries <= tries + 8'h01;
                        // Ceiling zero polls until a match; only reset stops it
                        if (poll_hit) begin // see RL4
                            state <= psfm_step;
                        end else if (word[step][`PSFM_POLL_LIMIT] != 8'h00 &&
                                     tries + 8'h01 >= word[step][`PSFM_POLL_LIMIT]) begin
                            error <= 1'b1; // see RL5
                            state <= psfm_step;
                        end
                    end else begin
                        if (kind == `PSFM_KIND_RX) begin
                            word[step][lane_pos +: 8] <= rsh; // see RL2
                            if (use_dma && (bcnt[1:0] == 2'h3 || last_byte)) begin
                                state <= psfm_push; // see RL8
                            end else if (last_byte) begin
                                state <= psfm_step;
                            end
                        end else if (last_byte) begin
                            state <= psfm_step;
                        end
                    end
                    // Step done: advance or close the transaction
                    if (state == psfm_end && (last_byte || kind == `PSFM_KIND_POLL) &&
                        !(kind == `PSFM_KIND_RX && use_dma)) begin
                        if (kind != `PSFM_KIND_POLL || poll_hit ||
                            (word[step][`PSFM_POLL_LIMIT] != 8'h00 &&
                             tries + 8'h01 >= word[step][`PSFM_POLL_LIMIT])) begin
                            if (step == step_total) begin // see RL1
                                state <= psfm_drain;
                                chip_select_n <= 1'b1; // see RL14
                                go <= 1'b0; // see RL3
                                io_oe <= 4'h0;
                            end else begin
                                step <= step + 3'h1;
                            end
                        end
                    end
                end
                psfm_push: begin
                    // Bus clock pauses while the buffer is full
                    if (rxs.in_ready) begin
                        state <= psfm_prep;
                        // Count already moved past the pushed byte, so compare it whole
                        if (bcnt == len) begin // see RL9
                            if (step == step_total) begin
                                state <= psfm_drain;
                                chip_select_n <= 1'b1;
                                go <= 1'b0; // see RL3
                                io_oe <= 4'h0;
                            end else begin
                                step <= step + 3'h1;
                                state <= psfm_step;
                            end
                        end
                    end
                end
                psfm_drain: begin
                    // Done waits for the DMA to take the last word
                    if (!rxs.out_valid) begin
                        done <= 1'b1;
                        state <= psfm_idle;
                    end
                end
                default: state <= psfm_idle;
            endcase
        end
    end
endmodule : psfm_top

// ==== include/psfm_map.svh ====
// Field positions, codes and timing constants of the phased serial flash master
`ifndef PSFM_MAP_SVH
`define PSFM_MAP_SVH

`define PSFM_STEPS 8
`define PSFM_WORD_W 32
`define PSFM_MODE_HI 21
`define PSFM_MODE_LO 20
`define PSFM_LEN_HI 19
`define PSFM_LEN_LO 8
`define PSFM_KIND_HI 5
`define PSFM_KIND_LO 4
`define PSFM_LANE_SINGLE 2'h0
`define PSFM_LANE_DUAL 2'h1
`define PSFM_LANE_QUAD 2'h2
`define PSFM_KIND_TX 2'h0
`define PSFM_KIND_DUMMY 2'h1
`define PSFM_KIND_RX 2'h2
`define PSFM_KIND_POLL 2'h3
`define PSFM_POLL_LIMIT 31:24
`define PSFM_POLL_MASK 23:16
`define PSFM_POLL_WANT 15:8
`define PSFM_POLL_READ 7:0
`define PSFM_FILLER 8'hff
`define PSFM_CLK_PERIOD_NS 10
`define PSFM_SCLK_PERIOD_NS 160
`define PSFM_HALF_CYC ((`PSFM_SCLK_PERIOD_NS) / (2 * `PSFM_CLK_PERIOD_NS))

`endif

// ==== include/psfm_pkg.sv ====
// Types shared by the phased serial flash master
package psfm_pkg;
    typedef enum logic [2:0] {
        psfm_idle,
        psfm_step,
        psfm_prep,
        psfm_low,
        psfm_high,
        psfm_end,
        psfm_push,
        psfm_drain
    } psfm_state_t;
    typedef logic [31:0] psfm_word_t;
endpackage : psfm_pkg

// ==== include/psfm_stream_if.sv ====
// Valid/ready word stream between the engine and its receive buffer
`timescale 1ns/1ps
interface psfm_stream_if #(parameter int W = 32);
    logic in_valid;
    logic in_ready;
    logic [W-1:0] in_data;
    logic out_valid;
    logic out_ready;
    logic [W-1:0] out_data;
    modport buffer (input in_valid, input in_data, input out_ready,
                    output in_ready, output out_valid, output out_data);
    modport user (output in_valid, output in_data, output out_ready,
                  input in_ready, input out_valid, input out_data);
endinterface : psfm_stream_if

// ==== verification/psfm_flash_model.sv ====
// Behavioural serial NOR flash answering the master's reads
`timescale 1ns/1ps
module psfm_flash_model (
    input wire logic chip_select_n,
    input wire logic sclk,
    input wire logic [3:0] io_out,
    input wire logic [2:0] width,
    input wire logic [7:0] status,
    output logic [3:0] io_in
);
    int p;
    int r;
    logic [7:0] cmd;
    logic [7:0] v;
    initial io_in = 4'h5;
    // Next bits of the current byte on the read lanes; other lanes toggle
    task automatic drive();
        v = (cmd == 8'h05 && r >= 8) ? status : 8'h30 + 8'(p / 8);
        v = v << (p % 8);
        io_in = ~io_in;
        if (width == 3'h4) io_in = v[7:4];
        else if (width == 3'h2) io_in[1:0] = v[7:6];
        else io_in[1] = v[7];
    endtask : drive
    // A new frame restarts the byte count
    always @(negedge chip_select_n) begin
        p = 0;
        r = 0;
        cmd = 8'h00;
        drive();
    end
    // First eight bits on io0 form the command
    always @(posedge sclk) begin
        if (!chip_select_n && r < 8) cmd = {cmd[6:0], io_out[0]};
        r++;
    end
    // Data moves on the falling edge, ahead of the master's sample
    always @(negedge sclk) begin
        if (!chip_select_n) begin
            p = p + width;
            drive();
        end
    end
    // Released lanes must not keep the last value
    always @(posedge chip_select_n) io_in = ~io_in;
endmodule : psfm_flash_model

// ==== verification/psfm_top_sva.sv ====
// Port-level assertions for the phased serial flash master
`timescale 1ns/1ps
`include "psfm_map.svh"
module psfm_top_sva #(
    parameter int HALF = `PSFM_HALF_CYC
) (
    input wire logic clock,
    input wire logic rst_b,
    input wire logic go_set,
    input wire logic [2:0] step_total,
    input wire logic byte_order_select,
    input wire logic use_dma,
    input wire logic [`PSFM_STEPS*32-1:0] step_setup,
    input wire logic [`PSFM_STEPS*32-1:0] step_word_in,
    input wire logic [3:0] io_in,
    input wire logic dma_ready,
    input wire psfm_pkg::psfm_word_t dma_data,
    input wire logic dma_req,
    input wire logic go,
    input wire logic error,
    input wire logic done,
    input wire logic chip_select_n,
    input wire logic sclk,
    input wire logic [3:0] io_out,
    input wire logic [3:0] io_oe,
    input wire logic [`PSFM_STEPS*32-1:0] step_word
);
    import psfm_pkg::*;
    int hi_cnt;
    // Length of the current high half, so a short or stretched pulse shows up
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            hi_cnt <= 0;
        end else begin
            hi_cnt <= sclk ? hi_cnt + 1 : 0;
        end
    end
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!rst_b);
    // Run ends with nothing left for the receiver
    sequence s_quiet_end; $fell(go) ##0 !dma_req; endsequence
    sequence s_idle2; !go ##1 !go; endsequence
    property p_start; $rose(go) |-> $past(go_set); endproperty
    a_start: assert property (p_start) else $error("go rose without start");
    property p_cs; go != chip_select_n; endproperty
    a_cs: assert property (p_cs) else $error("select and go disagree");
    property p_sclk_idle; chip_select_n |-> !sclk; endproperty
    a_sclk_idle: assert property (p_sclk_idle) else $error("serial clock outside frame");
    property p_done; s_quiet_end |-> ##[0:4] done; endproperty
    a_done: assert property (p_done) else $error("done missing after end");
    property p_done_clr; go |-> !done; endproperty
    a_done_clr: assert property (p_done_clr) else $error("done during run");
    property p_err_hold; s_idle2 |-> $stable(error); endproperty
    a_err_hold: assert property (p_err_hold) else $error("error moved while idle");
    property p_dma_hold; dma_req && !dma_ready |=> dma_req && $stable(dma_data); endproperty
    a_dma_hold: assert property (p_dma_hold) else $error("request dropped while stalled");
    property p_sclk_w; $fell(sclk) |-> hi_cnt == HALF; endproperty
    a_sclk_w: assert property (p_sclk_w) else $error("high half wrong length");
    property p_oe_idle; chip_select_n |-> io_oe == 4'h0; endproperty
    a_oe_idle: assert property (p_oe_idle) else $error("lanes driven outside frame");
endmodule : psfm_top_sva
bind psfm_top psfm_top_sva #(.HALF(HALF)) u_sva (.*);

// ==== verification/test_phased_serial_flash_master.sv ====
// Self-checking bench of the phased serial flash master with a flash model
`timescale 1ns/1ps
`include "psfm_map.svh"
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin errors++; $display("CHECK FAILED %0t mismatch", $time); end end
module test_phased_serial_flash_master;
    import psfm_pkg::*;
    logic clock = 0, rst_b = 0, go_set = 0, byte_order_select = 0, use_dma = 0, dma_ready = 0;
    logic [2:0] step_total = 0, fw = 1;
    logic [7:0] fst = 0;
    logic [255:0] step_setup = 0, step_word_in = 0, step_word;
    logic [3:0] io_in, io_out, io_oe;
    psfm_word_t dma_data;
    logic dma_req, go, error, done, chip_select_n, sclk;
    logic [1:0] kd [8];
    int ln [8], n [8];
    logic [31:0] wd [8];
    logic [3:0] nq [$];
    psfm_word_t dq [$];
    int errors = 0, total_checks = 0;
    psfm_top #(.HALF(2)) dut (.*);
    psfm_flash_model flash (.chip_select_n(chip_select_n), .sclk(sclk), .io_out(io_out), .width(fw),
        .status(fst), .io_in(io_in));
    initial forever #5 clock = ~clock;
    // Lanes at each serial clock rise, decoded per step afterwards
    always @(posedge sclk) if (!chip_select_n) nq.push_back(io_out);
    // Words taken by the receiver
    always @(posedge clock) if (dma_req && dma_ready) dq.push_back(dma_data);
    // Receiver is ready on about 3 in 100 cycles at random, so the buffer can fill and stall the engine
    always @(posedge clock) dma_ready <= #1 ($urandom % 100) < 3;
    task automatic st(input int i, input logic [1:0] k, input int l, input int len, input logic [31:0] w);
        kd[i] = k;
        ln[i] = l;
        n[i] = len;
        wd[i] = w;
        step_setup[i * 32 +: 32] = {10'h0, l[1:0], len[11:0], 2'h0, k, 4'h0};
        step_word_in[i * 32 +: 32] = w;
    endtask : st
    task automatic complete_run();
        $display("errors %0d checks %0d", errors, total_checks);
        if (errors == 0 && total_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : complete_run
    task automatic run(input int tot, input logic ord, input logic dm);
        int bits, cyc, b, m, k, q, sz, tn;
        logic [3:0] nib;
        logic [7:0] x, e0;
        logic [31:0] w;
        logic err;
        psfm_word_t ed [$];
        dq = {};
        nq = {};
        step_total = 3'(tot);
        byte_order_select = ord;
        use_dma = dm;
        fw = ln[tot] == 2 ? 3'h4 : ln[tot] == 1 ? 3'h2 : 3'h1;
        go_set = 1;
        @(posedge clock);
        #1;
        go_set = 0;
        for (cyc = 0; cyc < 20000 && done !== 1'b1; cyc++) begin
            @(posedge clock);
            #1;
        end
        if (cyc == 20000) begin
            errors++;
            complete_run();
        end
        sz = nq.size();
        bits = 0;
        tn = 0;
        err = 0;
        e0 = ord ? wd[0][7:0] : wd[0][31:24];
        for (int i = 0; i <= tot; i++) begin
            k = ln[i] == 2 ? 4 : ln[i] == 1 ? 2 : 1;
            w = wd[i];
            m = n[i];
            if (kd[i] == 2'h3) begin
                m = 1;
                if ((fst & w[23:16]) != w[15:8]) begin
                    m = w[31:24];
                    err = 1;
                end
            end
            for (b = 0; b < m; b++) begin
                x = 0;
                for (q = 0; q < 8 / k; q++) begin
                    nib = nq.pop_front();
                    x = 8'((x << k) | (nib & 4'((1 << k) - 1)));
                end
                tn += 8 / k;
                if (kd[i] == 2'h0) `CHK(x, ord ? w[8 * (b % 4) +: 8] : w[31 - 8 * (b % 4) -: 8])
                if (kd[i] == 2'h1) `CHK(x, 8'hff)
                if (kd[i] == 2'h2) begin
                    x = e0 == 8'h05 ? fst : 8'h30 + 8'(bits / 8);
                    if (ord) w[8 * (b % 4) +: 8] = x;
                    else w[31 - 8 * (b % 4) -: 8] = x;
                    if (dm && (b % 4 == 3 || b == m - 1)) ed.push_back(w);
                end
                bits += 8 * fw / k;
            end
            if (kd[i] == 2'h2 && !dm) `CHK(step_word[i * 32 +: 32], w)
            if (kd[i] == 2'h3) `CHK(step_word[i * 32 +: 8], fst)
        end
        `CHK(sz, tn)
        `CHK(error, err)
        `CHK({go, chip_select_n}, 2'b01)
        `CHK(dq.size(), ed.size())
        foreach (ed[j]) `CHK(dq[j], ed[j])
    endtask : run
    initial begin
        void'($urandom(22960));
        repeat (4) @(posedge clock);
        #1;
        rst_b = 1;
        @(posedge clock);
        #1;
        // One-byte command as a single step
        st(0, 2'h0, 0, 1, 32'h0600_0000);
        run(0, 0, 0);
        // Zero-length dummy step is skipped and closes the frame
        st(1, 2'h1, 0, 0, $urandom);
        run(1, 0, 0);
        // Status command, then four repeated status bytes
        fst = 8'($urandom);
        st(0, 2'h0, 0, 1, 32'h0000_0005);
        st(1, 2'h2, 0, 4, $urandom);
        run(1, 1, 0);
        // Quad fast read of 100 bytes through the stalled buffer, both byte orders
        st(0, 2'h0, 0, 1, 32'heb00_0000);
        st(1, 2'h0, 2, 4, 32'h1234_5678);
        st(2, 2'h1, 2, 2, $urandom);
        st(3, 2'h2, 2, 100, $urandom);
        run(3, 0, 1);
        st(0, 2'h0, 0, 1, 32'h0000_00eb);
        st(1, 2'h0, 2, 4, 32'h7856_3412);
        run(3, 1, 1);
        // Dual transmit wrapping its word, lane code three, dual receive past four bytes
        st(0, 2'h0, 1, 5, {24'($urandom), 8'h12});
        st(1, 2'h0, 3, 3, $urandom);
        st(2, 2'h2, 1, 6, $urandom);
        run(2, 1, 0);
        // Same dual receive through the buffer, ending one byte into a word
        st(2, 2'h2, 1, 5, $urandom);
        run(2, 1, 1);
        // Poll that matches at once, then one that runs out of attempts
        st(0, 2'h0, 0, 1, 32'h0500_0000);
        st(1, 2'h3, 0, 0, 32'h6401_0000);
        fst = 8'hfe;
        run(1, 0, 0);
        fst = 8'($urandom) | 8'h01;
        run(1, 0, 0);
        complete_run();
    end
endmodule : test_phased_serial_flash_master
